/* File: rtl/upi_pkg.sv */
/*
  Constants for the USB interface machine configuration bank.
  Assumes a 32-bit word register port with byte offsets.
*/
package upi_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int FLAG_W = 7;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_SOFT_RESET = 8'h00;
  localparam logic [7:0] OFS_SM_CTRL = 8'h04;
  localparam logic [7:0] OFS_DEV_ADDR = 8'h08;
  localparam logic [7:0] OFS_XCVR_FUNC = 8'h0c;
  localparam logic [7:0] OFS_OTG_CTRL = 8'h10;
  localparam logic [7:0] OFS_OTG_FLAGS = 8'h14;
  localparam logic [7:0] OFS_SERIAL = 8'h18;
  localparam logic [7:0] OFS_LINE_FLAGS = 8'h1c;
  localparam logic [7:0] OFS_STICKY = 8'h20;
  localparam logic [7:0] OFS_PORT_MASK = 8'h24;
  localparam logic [7:0] OFS_FRAME_NUM = 8'h28;
  localparam logic [7:0] OFS_LAST_PID = 8'h2c;
  localparam logic [7:0] OFS_LAST_EP = 8'h30;
  localparam logic [7:0] OFS_EP_MATCH = 8'h34;
  localparam logic [7:0] OFS_OTG_MASK = 8'h38;
  localparam logic [7:0] OFS_POWER_SIG = 8'h3c;
  localparam logic [7:0] OFS_XCVR_CTRL = 8'h40;
  // ----------------------------------------
  // Field layouts and reset values
  // ----------------------------------------
  localparam logic [31:0] SM_CTRL_MASK = 32'h0000_00f7;
  localparam logic [31:0] DEV_ADDR_MASK = 32'h0000_007f;
  localparam logic [31:0] XCVR_FUNC_MASK = 32'h0000_001f;
  localparam logic [31:0] XCVR_FUNC_RST = 32'h0000_0007;
  localparam logic [31:0] OTG_CTRL_MASK = 32'h0000_00df;
  localparam logic [31:0] SERIAL_MASK = 32'h0000_000f;
  localparam logic [31:0] SERIAL_RST = 32'h0000_0002;
  localparam logic [31:0] FLAG_MASK = 32'h0000_007f;
  localparam logic [31:0] FRAME_MASK = 32'h0000_07ff;
  localparam logic [31:0] EP_MATCH_MASK = 32'h0000_ffff;
  localparam logic [31:0] POWER_MASK = 32'h0000_01ff;
  localparam logic [31:0] XCVR_CTRL_MASK = 32'hffff_ffff;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam int SM_TOKEN_PROC = 0;
  localparam int SM_TOKEN_CHECK = 1;
  localparam int SM_LINE_DEC = 2;
  localparam int SM_IF_TIMING = 4;
  localparam int SM_POWER_SIG = 5;
  localparam int SM_SOF_TOKEN = 6;
  localparam int SM_ACK_EVENT = 7;
  localparam int OPMODE_LO = 2;
  localparam int TERM_BIT = 1;
  localparam int XCVR_BIT = 0;
  localparam int OTG_EXT_IND = 7;
  localparam int OTG_EXT_DRV = 6;
  localparam int OTG_CHRG = 4;
  localparam int OTG_DISCHRG = 3;
  localparam int OTG_DM_PD = 2;
  localparam int OTG_DP_PD = 1;
  localparam int OTG_ID_PU = 0;
  localparam int FLG_TOKEN = 6;
  localparam int FLG_SE0 = 5;
  localparam int FLG_K = 4;
  localparam int FLG_J = 3;
  localparam int FLG_CRC = 2;
  localparam int FLG_RXACT = 1;
  localparam int FLG_RXERR = 0;
  localparam logic [1:0] LS_SE0 = 2'h0;
  localparam logic [1:0] LS_J = 2'h1;
  localparam logic [1:0] LS_K = 2'h2;
endpackage

/* File: rtl/upi_config_bank.sv */
/*
  USB interface machine configuration bank: word register port, control
  outputs toward the transceiver and interface state, and flag logic.
  Assumes whole-word accesses on one clock; events come in synchronous.
*/
`timescale 1ns/10ps
module upi_config_bank (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [upi_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [upi_pkg::DATA_W-1:0] reg_wdata,
  output logic [upi_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_ack,
  output logic reg_err,
  // Transceiver status and packet events
  input wire logic [5:0] otg_status,
  input wire logic [1:0] line_state,
  input wire logic rx_active,
  input wire logic rx_error,
  input wire logic [2:0] serial_rx,
  input wire logic pkt_start,
  input wire logic token_valid,
  input wire logic [6:0] token_addr,
  input wire logic [3:0] token_pid,
  input wire logic [3:0] token_ep,
  input wire logic crc16_fail,
  // Transceiver controls
  output logic [2:0] op_mode,
  output logic term_select,
  output logic xcvr_select,
  output logic external_vbus_indicator,
  output logic external_vbus_drive,
  output logic vbus_charge,
  output logic vbus_discharge,
  output logic dm_pulldown,
  output logic dp_pulldown,
  output logic role_pin_pullup,
  // Interface machine controls
  output logic token_process_mode,
  output logic token_check_mode,
  output logic line_decoder_en,
  output logic if_timing_mode,
  output logic power_signal_mode,
  output logic frame_start_as_token,
  output logic ack_event_mode,
  output logic token_accept,
  output logic [2:0] flag_port
);
  import upi_pkg::*;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  logic mapped;
  logic soft_rst;
  logic [31:0] sm_ctrl_reg, dev_addr_reg, xcvr_func_reg, otg_ctrl_reg;
  logic [31:0] serial_reg, flags_reg, sticky_reg, port_mask_reg, frame_reg;
  logic [31:0] ep_match_reg, otg_mask_reg, power_reg, xcvr_ctrl_reg;
  logic [3:0] pid_reg;
  logic [4:0] ep_reg;
  logic [6:0] flag_set, flag_clr_wr;
  logic addr_match;

  assign mapped = (reg_addr[1:0] == 2'b00) && (reg_addr <= OFS_XCVR_CTRL);
  assign soft_rst = reg_wr && hit(reg_addr, OFS_SOFT_RESET);

  // Handshake answers in the same cycle
  assign reg_ack = (reg_wr || reg_rd) && mapped;
  assign reg_err = (reg_wr || reg_rd) && !mapped;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Transceiver selects survive the soft reset; only system reset touches them
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      xcvr_func_reg <= XCVR_FUNC_RST;
      otg_ctrl_reg <= ZERO_WORD;
      xcvr_ctrl_reg <= ZERO_WORD;
      serial_reg <= SERIAL_RST;
    end else if (reg_wr) begin
      if (hit(reg_addr, OFS_XCVR_FUNC)) begin
        xcvr_func_reg <= reg_wdata & XCVR_FUNC_MASK;
      end
      if (hit(reg_addr, OFS_OTG_CTRL)) begin
        otg_ctrl_reg <= reg_wdata & OTG_CTRL_MASK;
      end
      if (hit(reg_addr, OFS_XCVR_CTRL)) begin
        xcvr_ctrl_reg <= reg_wdata & XCVR_CTRL_MASK;
      end
      if (hit(reg_addr, OFS_SERIAL)) begin
        serial_reg <= reg_wdata & SERIAL_MASK;
      end
    end
  end

  // Interface machine state: cleared by system reset or soft reset
  always_ff @(posedge core_clk) begin
    if (!rst_n || soft_rst) begin
      sm_ctrl_reg <= ZERO_WORD;
      dev_addr_reg <= ZERO_WORD;
      sticky_reg <= ZERO_WORD;
      port_mask_reg <= ZERO_WORD;
      ep_match_reg <= ZERO_WORD;
      otg_mask_reg <= ZERO_WORD;
      power_reg <= ZERO_WORD;
    end else if (reg_wr) begin
      if (hit(reg_addr, OFS_SM_CTRL)) begin
        sm_ctrl_reg <= reg_wdata & SM_CTRL_MASK;
      end
      if (hit(reg_addr, OFS_DEV_ADDR)) begin
        dev_addr_reg <= reg_wdata & DEV_ADDR_MASK;
      end
      if (hit(reg_addr, OFS_STICKY)) begin
        sticky_reg <= reg_wdata & FLAG_MASK;
      end
      if (hit(reg_addr, OFS_PORT_MASK)) begin
        port_mask_reg <= reg_wdata;
      end
      if (hit(reg_addr, OFS_EP_MATCH)) begin
        ep_match_reg <= reg_wdata & EP_MATCH_MASK;
      end
      if (hit(reg_addr, OFS_OTG_MASK)) begin
        otg_mask_reg <= reg_wdata;
      end
      if (hit(reg_addr, OFS_POWER_SIG)) begin
        power_reg <= reg_wdata & POWER_MASK;
      end
    end
  end

  // ----------------------------------------
  // Packet capture and flags
  // ----------------------------------------
  assign addr_match = token_valid && (token_addr == dev_addr_reg[6:0]);
  assign token_accept = addr_match;

  always_comb begin
    flag_set = '0;
    flag_set[FLG_TOKEN] = addr_match;
    flag_set[FLG_SE0] = sm_ctrl_reg[SM_LINE_DEC] && (line_state == LS_SE0);
    flag_set[FLG_K] = sm_ctrl_reg[SM_LINE_DEC] && (line_state == LS_K);
    flag_set[FLG_J] = sm_ctrl_reg[SM_LINE_DEC] && (line_state == LS_J);
    flag_set[FLG_CRC] = crc16_fail;
    flag_set[FLG_RXACT] = rx_active;
    flag_set[FLG_RXERR] = rx_error;
    flag_clr_wr = (reg_wr && hit(reg_addr, OFS_LINE_FLAGS)) ? reg_wdata[6:0] : 7'h00;
  end

  // Set wins over any clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n || soft_rst) begin
      flags_reg <= ZERO_WORD;
    end else begin
      for (int i = 0; i < FLAG_W; i++) begin
        if (flag_set[i]) begin
          flags_reg[i] <= 1'b1;
        end else if (sticky_reg[i]) begin
          if (flag_clr_wr[i]) begin
            flags_reg[i] <= 1'b0;
          end
        end else if (pkt_start || flag_clr_wr[i]) begin
          flags_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Frame number: written by software only; last PID and endpoint loaded from accepted tokens
  always_ff @(posedge core_clk) begin
    if (!rst_n || soft_rst) begin
      frame_reg <= ZERO_WORD;
      pid_reg <= 4'h0;
      ep_reg <= 5'h00;
    end else begin
      if (reg_wr && hit(reg_addr, OFS_FRAME_NUM)) begin
        frame_reg <= reg_wdata & FRAME_MASK;
      end
      if (addr_match) begin
        pid_reg <= token_pid;
        ep_reg <= {1'b1, token_ep};
      end
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= ZERO_WORD;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_SM_CTRL: reg_rdata <= sm_ctrl_reg;
        OFS_DEV_ADDR: reg_rdata <= dev_addr_reg;
        OFS_XCVR_FUNC: reg_rdata <= xcvr_func_reg;
        OFS_OTG_CTRL: reg_rdata <= otg_ctrl_reg;
        OFS_OTG_FLAGS: reg_rdata <= {26'h0, otg_status};
        OFS_SERIAL: reg_rdata <= {25'h0, serial_rx, serial_reg[3:0]};
        OFS_LINE_FLAGS: reg_rdata <= flags_reg;
        OFS_STICKY: reg_rdata <= sticky_reg;
        OFS_PORT_MASK: reg_rdata <= port_mask_reg;
        OFS_FRAME_NUM: reg_rdata <= frame_reg;
        OFS_LAST_PID: reg_rdata <= {28'h0, pid_reg};
        OFS_LAST_EP: reg_rdata <= {27'h0, ep_reg};
        OFS_EP_MATCH: reg_rdata <= ep_match_reg;
        OFS_OTG_MASK: reg_rdata <= otg_mask_reg;
        OFS_POWER_SIG: reg_rdata <= power_reg;
        OFS_XCVR_CTRL: reg_rdata <= xcvr_ctrl_reg;
        default: reg_rdata <= ZERO_WORD;
      endcase
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign op_mode = xcvr_func_reg[OPMODE_LO +: 3];
  assign term_select = xcvr_func_reg[TERM_BIT];
  assign xcvr_select = xcvr_func_reg[XCVR_BIT];
  assign external_vbus_indicator = otg_ctrl_reg[OTG_EXT_IND];
  assign external_vbus_drive = otg_ctrl_reg[OTG_EXT_DRV];
  assign vbus_charge = otg_ctrl_reg[OTG_CHRG];
  assign vbus_discharge = otg_ctrl_reg[OTG_DISCHRG];
  assign dm_pulldown = otg_ctrl_reg[OTG_DM_PD];
  assign dp_pulldown = otg_ctrl_reg[OTG_DP_PD];
  assign role_pin_pullup = otg_ctrl_reg[OTG_ID_PU];
  assign token_process_mode = sm_ctrl_reg[SM_TOKEN_PROC];
  assign token_check_mode = sm_ctrl_reg[SM_TOKEN_CHECK];
  assign line_decoder_en = sm_ctrl_reg[SM_LINE_DEC];
  assign if_timing_mode = sm_ctrl_reg[SM_IF_TIMING];
  assign power_signal_mode = sm_ctrl_reg[SM_POWER_SIG];
  assign frame_start_as_token = sm_ctrl_reg[SM_SOF_TOKEN];
  assign ack_event_mode = sm_ctrl_reg[SM_ACK_EVENT];
  assign flag_port[0] = |(flags_reg[6:0] & port_mask_reg[6:0]);
  assign flag_port[1] = |(flags_reg[6:0] & port_mask_reg[14:8]);
  assign flag_port[2] = |(flags_reg[6:0] & port_mask_reg[22:16]);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence soft_reset_write;
    reg_wr && reg_addr == OFS_SOFT_RESET;
  endsequence

  sequence packet_clears_error;
    pkt_start && !sticky_reg[FLG_RXERR] && !rx_error;
  endsequence

  soft_reset_clears_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    soft_reset_write |=> sm_ctrl_reg == ZERO_WORD && dev_addr_reg == ZERO_WORD
      && flags_reg == ZERO_WORD && pid_reg == 4'h0)
    else $error("soft reset left state");
  soft_reset_keeps_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    soft_reset_write |=> $stable(xcvr_func_reg) && $stable(otg_ctrl_reg))
    else $error("soft reset touched transceiver");
  token_bits_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_wr && reg_addr == OFS_SM_CTRL |=>
      token_process_mode == $past(reg_wdata[0]) && token_check_mode == $past(reg_wdata[1]))
    else $error("token enables wrong");
  ctrl_reserved_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    sm_ctrl_reg[3] == 1'b0 && sm_ctrl_reg[31:8] == 24'h0)
    else $error("reserved control bit set");
  mode_bits_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_wr && reg_addr == OFS_SM_CTRL |=> if_timing_mode == $past(reg_wdata[4])
      && power_signal_mode == $past(reg_wdata[5]) && ack_event_mode == $past(reg_wdata[7]))
    else $error("mode bits wrong");
  sof_bit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_wr && reg_addr == OFS_SM_CTRL |=> frame_start_as_token == $past(reg_wdata[6]))
    else $error("frame start bit wrong");
  addr_filter_a: assert property (@(posedge core_clk) disable iff (!rst_n || soft_rst)
    token_accept |-> token_addr == dev_addr_reg[6:0]
      ##1 flags_reg[FLG_TOKEN] && pid_reg == $past(token_pid) && ep_reg[4])
    else $error("foreign address accepted");
  opmode_drive_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_wr && reg_addr == OFS_XCVR_FUNC |=> op_mode == $past(reg_wdata[4:2]))
    else $error("operating mode wrong");
  func_select_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_wr && reg_addr == OFS_XCVR_FUNC |=> term_select == $past(reg_wdata[1])
      && xcvr_select == $past(reg_wdata[0]))
    else $error("selects wrong");
  otg_vbus_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_wr && reg_addr == OFS_OTG_CTRL |=> external_vbus_indicator == $past(reg_wdata[7])
      && external_vbus_drive == $past(reg_wdata[6]))
    else $error("vbus selects wrong");
  otg_charge_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_wr && reg_addr == OFS_OTG_CTRL |=> vbus_charge == $past(reg_wdata[4])
      && vbus_discharge == $past(reg_wdata[3]) && otg_ctrl_reg[5] == 1'b0)
    else $error("charge bits wrong");
  otg_pulls_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_wr && reg_addr == OFS_OTG_CTRL |=> dm_pulldown == $past(reg_wdata[2])
      && dp_pulldown == $past(reg_wdata[1]) && role_pin_pullup == $past(reg_wdata[0]))
    else $error("pull controls wrong");
  sticky_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n || soft_rst)
    flags_reg[FLG_CRC] && sticky_reg[FLG_CRC] && pkt_start && !flag_clr_wr[FLG_CRC]
      |=> flags_reg[FLG_CRC])
    else $error("sticky flag lost");
  reset_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFS_SOFT_RESET |=> reg_rdata == ZERO_WORD)
    else $error("reset register read nonzero");
  reset_read_keeps_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_rd && !reg_wr && reg_addr == OFS_SOFT_RESET |=> $stable(sm_ctrl_reg))
    else $error("reset register read cleared state");
  reg_range_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (reg_wr || reg_rd) && reg_addr > OFS_XCVR_CTRL |-> reg_err && !reg_ack)
    else $error("access above bank not refused");
  write_ack_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_wr && reg_addr == OFS_OTG_CTRL |-> reg_ack && !reg_err)
    else $error("mapped write not acknowledged");
  reg_align_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    reg_wr && reg_addr[1:0] != 2'b00 |-> reg_err ##1 $stable(sm_ctrl_reg))
    else $error("partial word access taken");
  flag_set_a: assert property (@(posedge core_clk) disable iff (!rst_n || soft_rst)
    rx_error |=> flags_reg[FLG_RXERR])
    else $error("error flag not set");
  flag_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n || soft_rst)
    packet_clears_error |=> !flags_reg[FLG_RXERR])
    else $error("plain flag not cleared by packet");
endmodule

/* File: tb/upi_xcvr_model.sv */
/*
  Transceiver-side model for the configuration bank: line and status levels
  and one-cycle packet, token and error pulses, each launched on request.
  Assumes the bench raises a request on a rising edge for one cycle.
*/
`timescale 1ns/10ps
module upi_xcvr_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Requests from the bench
  input wire logic req_tok,
  input wire logic [6:0] req_addr,
  input wire logic [3:0] req_pid,
  input wire logic [3:0] req_ep,
  input wire logic req_pkt,
  input wire logic req_crc,
  input wire logic req_err,
  input wire logic [1:0] req_ls,
  input wire logic [5:0] req_otg,
  input wire logic [2:0] req_ser,
  // Transceiver side of the bank
  output logic [5:0] otg_status,
  output logic [1:0] line_state,
  output logic rx_active,
  output logic rx_error,
  output logic [2:0] serial_rx,
  output logic pkt_start,
  output logic token_valid,
  output logic [6:0] token_addr,
  output logic [3:0] token_pid,
  output logic [3:0] token_ep,
  output logic crc16_fail
);
  always_ff @(posedge core_clk) begin
    otg_status <= req_otg;
    line_state <= req_ls;
    serial_rx <= req_ser;
  end
  always_ff @(posedge core_clk) begin
    pkt_start <= rst_n & req_pkt;
    rx_active <= rst_n & req_pkt;
    rx_error <= rst_n & req_err;
    crc16_fail <= rst_n & req_crc;
    token_valid <= rst_n & req_tok;
  end
  // Idle token fields toggle so a stale value is never mistaken for a live one
  always_ff @(posedge core_clk) begin
    if (req_tok) begin
      token_addr <= req_addr;
      token_pid <= req_pid;
      token_ep <= req_ep;
    end else begin
      token_addr <= ~token_addr;
      token_pid <= ~token_pid;
      token_ep <= ~token_ep;
    end
  end
endmodule

/* File: tb/upi_config_bank_tb.sv */
/*
  Self-checking bench for the configuration bank: word register accesses,
  soft reset, address filter and flag behaviour.
  Assumes the transceiver model of upi_xcvr_model on the far side.
*/
`timescale 1ns/10ps
module upi_config_bank_tb;
  import upi_pkg::*;
  logic core_clk, rst_n, reg_wr, reg_rd, req_tok, req_pkt, req_crc, req_err, ack, err, acc;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd, d;
  logic reg_ack, reg_err, rx_active, rx_error, pkt_start, token_valid, crc16_fail;
  logic [6:0] req_addr, token_addr;
  logic [3:0] req_pid, req_ep, token_pid, token_ep;
  logic [1:0] req_ls, line_state;
  logic [5:0] req_otg, otg_status;
  logic [2:0] req_ser, serial_rx, op_mode, flag_port;
  logic term_select, xcvr_select, external_vbus_indicator, external_vbus_drive, vbus_charge;
  logic vbus_discharge, dm_pulldown, dp_pulldown, role_pin_pullup, token_process_mode;
  logic token_check_mode, line_decoder_en, if_timing_mode, power_signal_mode;
  logic frame_start_as_token, ack_event_mode, token_accept;
  logic [31:0] shadow [0:16];
  int err_count = 0, tests_run = 0, cycles = 0, seed = 43;

  upi_config_bank dut_u (.core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .reg_err(reg_err), .otg_status(otg_status), .line_state(line_state),
    .rx_active(rx_active), .rx_error(rx_error), .serial_rx(serial_rx), .pkt_start(pkt_start),
    .token_valid(token_valid), .token_addr(token_addr), .token_pid(token_pid),
    .token_ep(token_ep), .crc16_fail(crc16_fail), .op_mode(op_mode),
    .term_select(term_select), .xcvr_select(xcvr_select),
    .external_vbus_indicator(external_vbus_indicator),
    .external_vbus_drive(external_vbus_drive), .vbus_charge(vbus_charge),
    .vbus_discharge(vbus_discharge), .dm_pulldown(dm_pulldown), .dp_pulldown(dp_pulldown),
    .role_pin_pullup(role_pin_pullup), .token_process_mode(token_process_mode),
    .token_check_mode(token_check_mode), .line_decoder_en(line_decoder_en),
    .if_timing_mode(if_timing_mode), .power_signal_mode(power_signal_mode),
    .frame_start_as_token(frame_start_as_token), .ack_event_mode(ack_event_mode),
    .token_accept(token_accept), .flag_port(flag_port));
  upi_xcvr_model model_u (.core_clk(core_clk), .rst_n(rst_n), .req_tok(req_tok),
    .req_addr(req_addr), .req_pid(req_pid), .req_ep(req_ep), .req_pkt(req_pkt),
    .req_crc(req_crc), .req_err(req_err), .req_ls(req_ls), .req_otg(req_otg),
    .req_ser(req_ser), .otg_status(otg_status), .line_state(line_state),
    .rx_active(rx_active), .rx_error(rx_error), .serial_rx(serial_rx), .pkt_start(pkt_start),
    .token_valid(token_valid), .token_addr(token_addr), .token_pid(token_pid),
    .token_ep(token_ep), .crc16_fail(crc16_fail));

  // ----------------------------------------
  // Expectations and helpers
  // ----------------------------------------
  function automatic logic [31:0] rw_mask(input logic [7:0] o);
    case (o)
      OFS_SM_CTRL: return SM_CTRL_MASK;
      OFS_DEV_ADDR: return DEV_ADDR_MASK;
      OFS_XCVR_FUNC: return XCVR_FUNC_MASK;
      OFS_OTG_CTRL: return OTG_CTRL_MASK;
      OFS_SERIAL: return SERIAL_MASK;
      OFS_STICKY: return FLAG_MASK;
      OFS_FRAME_NUM: return FRAME_MASK;
      OFS_EP_MATCH: return EP_MATCH_MASK;
      OFS_OTG_MASK: return 32'hffff_ffff;
      OFS_POWER_SIG: return POWER_MASK;
      OFS_XCVR_CTRL: return XCVR_CTRL_MASK;
      default: return ZERO_WORD;
    endcase
  endfunction
  // Status fields that reflect the model's live levels
  function automatic logic [31:0] ro_part(input logic [7:0] o);
    if (o == OFS_OTG_FLAGS) return {26'h0, req_otg};
    if (o == OFS_SERIAL) return {25'h0, req_ser, 4'h0};
    return ZERO_WORD;
  endfunction
  function automatic logic [31:0] expect_word(input logic [7:0] o, input logic [31:0] w);
    return (w & rw_mask(o)) | ro_part(o);
  endfunction
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic check_outputs(input logic [31:0] s4, input logic [31:0] sc, input logic [31:0] s10);
    check_word({24'h0, ack_event_mode, frame_start_as_token, power_signal_mode, if_timing_mode,
      1'b0, line_decoder_en, token_check_mode, token_process_mode}, s4 & SM_CTRL_MASK);
    check_word({27'h0, op_mode, term_select, xcvr_select}, sc & XCVR_FUNC_MASK);
    check_word({24'h0, external_vbus_indicator, external_vbus_drive, 1'b0, vbus_charge,
      vbus_discharge, dm_pulldown, dp_pulldown, role_pin_pullup}, s10 & OTG_CTRL_MASK);
  endtask
  // One access; strobe held to the taking edge, data caught on the falling edge after it
  task automatic reg_op(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    reg_wr <= wr;
    reg_rd <= ~wr;
    reg_addr <= a;
    reg_wdata <= wd;
    @(negedge core_clk);
    ack = reg_ack;
    err = reg_err;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(negedge core_clk);
    rd = reg_rdata;
  endtask
  task automatic send_tok(input logic [6:0] a);
    @(posedge core_clk);
    d = $random(seed);
    req_tok <= 1'b1;
    req_addr <= a;
    req_pid <= d[3:0];
    req_ep <= d[7:4];
    @(posedge core_clk);
    req_tok <= 1'b0;
    #1 acc = token_accept;
    @(posedge core_clk);
  endtask
  task automatic pulse(input logic p, input logic c, input logic e);
    @(posedge core_clk);
    req_pkt <= p;
    req_crc <= c;
    req_err <= e;
    @(posedge core_clk);
    req_pkt <= 1'b0;
    req_crc <= 1'b0;
    req_err <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic conclude();
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Whole run needs well under two thousand cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      conclude();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    {reg_wr, reg_rd, req_tok, req_pkt, req_crc, req_err} = 6'h00;
    {reg_addr, reg_wdata, req_addr, req_pid, req_ep} = 55'h0;
    req_ls = LS_J;
    d = $random(seed);
    req_otg = d[5:0];
    req_ser = d[8:6];
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    check_outputs(ZERO_WORD, XCVR_FUNC_RST, ZERO_WORD);
    for (int o = 4; o <= 64; o += 4) begin
      reg_op(1'b0, 8'(o), ZERO_WORD);
      d = (o == 12) ? XCVR_FUNC_RST : (o == 24) ? SERIAL_RST : ZERO_WORD;
      check_word(rd, expect_word(8'(o), d));
      check_bit(ack, 1'b1);
    end
    for (int p = 0; p < 3; p++) begin
      for (int o = 4; o <= 64; o += 4) begin
        if (o == 28 || o == 36) continue;
        d = (p == 0) ? 32'hffff_ffff : $random(seed);
        reg_op(1'b1, 8'(o), d);
        shadow[o / 4] = d;
        reg_op(1'b0, 8'(o), ZERO_WORD);
        check_word(rd, expect_word(8'(o), d));
      end
      check_outputs(shadow[1], shadow[3], shadow[4]);
    end
    reg_op(1'b0, 8'h44, ZERO_WORD);
    check_bit(err, 1'b1);
    check_word(rd, ZERO_WORD);
    reg_op(1'b1, 8'h06, 32'hffff_ffff);
    check_bit(err, 1'b1);
    reg_op(1'b1, OFS_SM_CTRL, 32'h0000_00ff);
    reg_op(1'b0, OFS_SOFT_RESET, ZERO_WORD);
    check_word(rd, ZERO_WORD);
    reg_op(1'b0, OFS_SM_CTRL, ZERO_WORD);
    check_word(rd, SM_CTRL_MASK);
    reg_op(1'b1, OFS_SOFT_RESET, $random(seed));
    for (int o = 4; o <= 64; o += 4) begin
      reg_op(1'b0, 8'(o), ZERO_WORD);
      d = (o == 12 || o == 16 || o == 24 || o == 64) ? shadow[o / 4] : ZERO_WORD;
      check_word(rd, expect_word(8'(o), d));
    end
    check_outputs(ZERO_WORD, shadow[3], shadow[4]);
    send_tok(7'h00);
    check_bit(acc, 1'b1);
    reg_op(1'b1, OFS_DEV_ADDR, 32'h0000_002a);
    send_tok(7'h2b);
    check_bit(acc, 1'b0);
    send_tok(7'h2a);
    check_bit(acc, 1'b1);
    reg_op(1'b0, OFS_LAST_PID, ZERO_WORD);
    check_word(rd, {28'h0, req_pid});
    reg_op(1'b0, OFS_LAST_EP, ZERO_WORD);
    check_word(rd, {27'h0, 1'b1, req_ep});
    reg_op(1'b1, OFS_STICKY, 32'h0000_0004);
    reg_op(1'b1, OFS_PORT_MASK, 32'h0001_0404);
    pulse(1'b0, 1'b1, 1'b1);
    reg_op(1'b0, OFS_LINE_FLAGS, ZERO_WORD);
    check_word(rd & 32'h0000_0005, 32'h0000_0005);
    check_word({29'h0, flag_port}, 32'h0000_0007);
    pulse(1'b1, 1'b0, 1'b0);
    reg_op(1'b0, OFS_LINE_FLAGS, ZERO_WORD);
    check_word(rd & 32'h0000_0005, 32'h0000_0004);
    check_word({29'h0, flag_port}, 32'h0000_0003);
    reg_op(1'b1, OFS_LINE_FLAGS, 32'h0000_0004);
    reg_op(1'b0, OFS_LINE_FLAGS, ZERO_WORD);
    check_word(rd & 32'h0000_0005, ZERO_WORD);
    check_word({29'h0, flag_port}, ZERO_WORD);
    @(posedge core_clk);
    req_ls <= LS_K;
    pulse(1'b1, 1'b0, 1'b0);
    reg_op(1'b0, OFS_LINE_FLAGS, ZERO_WORD);
    check_bit(rd[FLG_K], 1'b0);
    reg_op(1'b1, OFS_SM_CTRL, 32'h0000_0004);
    check_bit(line_decoder_en, 1'b1);
    reg_op(1'b0, OFS_LINE_FLAGS, ZERO_WORD);
    check_bit(rd[FLG_K], 1'b1);
    conclude();
  end
endmodule
